// File: design/sscl_defines.svh
/*
  constants for the serial configuration load block: word layout, select codes,
  power and output control fields, timing.
  assumes: included by the package and the modules by bare name.
*/
// Overview of operation
// - words shift in most significant bit first
// - leading bits select the target latch
// - data sampled on serial clock rising edge
// - load strobe rise copies word to latch
// - enable powers only sections enabled by bits
// - programming accepted while chip enable low
// - open-drain pin: fast-settle or general output
// - lock monitor pin muxes internal signals
// - fast-settle applies alternate loop filter settings
`ifndef SSCL_DEFINES_SVH
`define SSCL_DEFINES_SVH
`define SSCL_WORD_W 24
`define SSCL_SEL_W 4
`define SSCL_DATA_W 20
`define SSCL_NLATCH 16
`define SSCL_SEL_CFG0 4'h0
`define SSCL_SEL_PWR 4'h1
`define SSCL_SEL_OUT 4'h2
`define SSCL_SEL_LF 4'h3
`define SSCL_PWR_W 4
`define SSCL_PWR_RST 4'hF
`define SSCL_FL_MODE_BIT 0
`define SSCL_FL_GPO_BIT 1
`define SSCL_MUX_LSB 4
`define SSCL_MUX_W 3
`define SSCL_FS_TIME_US 10
`define SSCL_CLK_MHZ 25
`define SSCL_FS_CYCLES (`SSCL_FS_TIME_US * `SSCL_CLK_MHZ)
`define SSCL_LF_W 8
`endif

// File: design/sscl_pkg.sv
/*
  types for the serial configuration load block.
  assumes: sscl_defines.svh is on the include path.
*/
`include "sscl_defines.svh"
package sscl_pkg;
  typedef struct packed {
    logic [`SSCL_SEL_W-1:0] sel;
    logic [`SSCL_DATA_W-1:0] data;
  } sscl_word_type;
  typedef enum logic [`SSCL_MUX_W-1:0] {
    SSCL_MUX_LOW, SSCL_MUX_LOCK, SSCL_MUX_HIGH, SSCL_MUX_FS,
    SSCL_MUX_PWR, SSCL_MUX_ENABLE, SSCL_MUX_RSV6, SSCL_MUX_RSV7
  } sscl_mux_type;
  typedef enum {SSCL_IDLE, SSCL_SETTLE} sscl_fs_state_type;
endpackage

// File: design/sscl_latch_mem.sv
/*
  latch register bank: one word per select code, registered read port.
  assumes: single clock, written at most once per cycle.
*/
`timescale 1ns/10ps
`include "sscl_defines.svh"
module sscl_latch_mem (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic we_i,
  input wire logic [`SSCL_SEL_W-1:0] waddr_i,
  input wire logic [`SSCL_DATA_W-1:0] wdata_i,
  input wire logic [`SSCL_SEL_W-1:0] raddr_i,
  output logic [`SSCL_DATA_W-1:0] rdata_o
);
  logic [`SSCL_DATA_W-1:0] mem_q [`SSCL_NLATCH];
  always_ff @(posedge mclk_i) begin
    if (we_i) begin
      mem_q[waddr_i] <= wdata_i;
    end
  end
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= mem_q[raddr_i];
    end
  end
endmodule // sscl_latch_mem

// File: design/sscl_top.sv
/*
  serial configuration port of a synthesizer: shift register on the serial
  clock, load strobe transfer into selected latches, chip enable power gating,
  fast-settle open-drain pin and lock monitor mux.
  assumes: serial clock runs only during frames; load strobe and chip enable
  are asynchronous pins; lock status is asynchronous too and passes a 2-stage sync onto mclk_i.
*/
`timescale 1ns/10ps
`include "sscl_defines.svh"
module sscl_top
  import sscl_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic ser_clk_i,
  input wire logic ser_data_i,
  input wire logic load_strobe_i,
  input wire logic chip_en_i,
  input wire logic pll_locked_i,
  output logic [`SSCL_PWR_W-1:0] pwr_on_o,
  output logic relock_start_o,
  output logic fast_settle_output_o,
  output logic fast_settle_output_oe_o,
  output logic lock_monitor_output_o,
  output logic [`SSCL_LF_W-1:0] loop_filter_o,
  output logic [`SSCL_DATA_W-1:0] cfg0_o
);
  localparam int FS_CNT_W = 16;
  localparam logic [FS_CNT_W-1:0] FS_CYCLES = FS_CNT_W'(`SSCL_FS_CYCLES);

  // serial clock domain: shift register, msb first, no reset because the
  // serial clock does not run outside frames; mclk samples a copy every cycle
  logic [`SSCL_WORD_W-1:0] shift_q;
  always_ff @(posedge ser_clk_i) begin
    shift_q <= {shift_q[`SSCL_WORD_W-2:0], ser_data_i};
  end

  // strobe edge in the serial domain cannot be relied on (no clock then), so
  // the shift contents are held stable by the host, sampled on mclk every
  // cycle and written at the synchronised strobe edge; host keeps serial clock idle while high
  logic [2:0] le_sync_q;
  logic [1:0] ce_sync_q;
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      le_sync_q <= 3'h0;
      ce_sync_q <= 2'h0;
    end else begin
      le_sync_q <= {le_sync_q[1:0], load_strobe_i};
      ce_sync_q <= {ce_sync_q[0], chip_en_i};
    end
  end
  wire le_rise = le_sync_q[1] & ~le_sync_q[2];
  wire ce_lvl = ce_sync_q[1];

  // two-stage capture of the quasi-static shift word, taken every mclk cycle
  logic [`SSCL_WORD_W-1:0] word_meta_q;
  logic [`SSCL_WORD_W-1:0] word_sync_q;
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      word_meta_q <= '0;
      word_sync_q <= '0;
    end else begin
      word_meta_q <= shift_q;
      word_sync_q <= word_meta_q;
    end
  end
  sscl_word_type word;
  assign word = sscl_word_type'(word_sync_q);
  // leading bits are the select field
  wire [`SSCL_SEL_W-1:0] sel = word.sel;
  wire load_en = le_rise; // no chip enable gating

  sscl_latch_mem u_mem (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .we_i(load_en),
    .waddr_i(sel),
    .wdata_i(word.data),
    .raddr_i(sel),
    .rdata_o()
  );

  // control latches kept locally too: they steer logic every cycle
  logic [`SSCL_DATA_W-1:0] cfg0_q;
  logic [`SSCL_PWR_W-1:0] pwr_bits_q;
  logic [`SSCL_DATA_W-1:0] out_cfg_q;
  logic [`SSCL_LF_W-1:0] lf_norm_q;
  logic [`SSCL_LF_W-1:0] lf_fast_q;
  // one decode shared by every control latch write and by the relock path
  function automatic logic sel_is(
    input logic [`SSCL_SEL_W-1:0] code,
    input logic [`SSCL_SEL_W-1:0] want
  );
    return code == want;
  endfunction
  wire ld_cfg0 = load_en && sel_is(sel, `SSCL_SEL_CFG0);
  wire ld_pwr = load_en && sel_is(sel, `SSCL_SEL_PWR);
  wire ld_out = load_en && sel_is(sel, `SSCL_SEL_OUT);
  // codes 4..15 only reach the bank: they steer nothing here
  wire ld_lf = load_en && sel_is(sel, `SSCL_SEL_LF);

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg0_q <= '0;
    end else if (ld_cfg0) begin
      cfg0_q <= word.data;
    end
  end

  // power bits reset to all sections on, so raising chip enable before any
  // power load wakes the whole device
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pwr_bits_q <= `SSCL_PWR_RST;
    end else if (ld_pwr) begin
      pwr_bits_q <= word.data[`SSCL_PWR_W-1:0];
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      out_cfg_q <= '0;
    end else if (ld_out) begin
      out_cfg_q <= word.data;
    end
  end

  // the fast set only reaches the output inside the fast-settle window
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      lf_norm_q <= '0;
      lf_fast_q <= '0;
    end else if (ld_lf) begin
      lf_norm_q <= word.data[`SSCL_LF_W-1:0];
      lf_fast_q <= word.data[2*`SSCL_LF_W-1:`SSCL_LF_W];
    end
  end

  // relock: only a first-word write while enabled starts acquisition,
  // which is why the host must rewrite it after power-up
  logic armed_q;
  logic relock_q;
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      armed_q <= 1'b0;
      relock_q <= 1'b0;
    end else begin
      relock_q <= ld_cfg0 & ce_lvl;
      if (!ce_lvl) begin
        armed_q <= 1'b0;
      end else if (ld_cfg0) begin
        armed_q <= 1'b1;
      end
    end
  end

  // fast-settle window after a relock arriving in idle while the pin is in fast-settle mode
  sscl_fs_state_type fs_state_q;
  logic [FS_CNT_W-1:0] fs_cnt_q;
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      fs_state_q <= SSCL_IDLE;
      fs_cnt_q <= '0;
    end else begin
      unique case (fs_state_q)
        SSCL_IDLE: if (relock_q && out_cfg_q[`SSCL_FL_MODE_BIT]) begin
          fs_state_q <= SSCL_SETTLE;
          fs_cnt_q <= FS_CYCLES - FS_CNT_W'(1);
        end
        SSCL_SETTLE: begin
          if (!ce_lvl || fs_cnt_q == '0) begin
            fs_state_q <= SSCL_IDLE;
          end else begin
            fs_cnt_q <= fs_cnt_q - FS_CNT_W'(1);
          end
        end
      endcase
    end
  end
  wire fs_active = fs_state_q == SSCL_SETTLE;

  // open drain: pin pulls low when asserted, released otherwise
  wire fl_pull = out_cfg_q[`SSCL_FL_MODE_BIT] ? fs_active
                 : out_cfg_q[`SSCL_FL_GPO_BIT];

  logic [1:0] lock_sync_q;
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      lock_sync_q <= 2'h0;
    end else begin
      lock_sync_q <= {lock_sync_q[0], pll_locked_i};
    end
  end
  sscl_mux_type mux_sel;
  assign mux_sel = sscl_mux_type'(out_cfg_q[`SSCL_MUX_LSB +: `SSCL_MUX_W]);
  logic mux_val;
  always_comb begin
    unique case (mux_sel)
      SSCL_MUX_LOW: mux_val = 1'b0;
      SSCL_MUX_LOCK: mux_val = lock_sync_q[1] & armed_q;
      SSCL_MUX_HIGH: mux_val = 1'b1;
      SSCL_MUX_FS: mux_val = fs_active;
      SSCL_MUX_PWR: mux_val = |pwr_on_o;
      SSCL_MUX_ENABLE: mux_val = ce_lvl;
      default: mux_val = 1'b0;
    endcase
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pwr_on_o <= '0;
      relock_start_o <= 1'b0;
      fast_settle_output_o <= 1'b0;
      fast_settle_output_oe_o <= 1'b0;
      lock_monitor_output_o <= 1'b0;
      loop_filter_o <= '0;
      cfg0_o <= '0;
    end else begin
      pwr_on_o <= ce_lvl ? pwr_bits_q : '0;
      relock_start_o <= relock_q;
      fast_settle_output_o <= 1'b0;
      fast_settle_output_oe_o <= fl_pull;
      lock_monitor_output_o <= mux_val;
      loop_filter_o <= fs_active ? lf_fast_q : lf_norm_q;
      cfg0_o <= cfg0_q;
    end
  end
endmodule // sscl_top

// File: dv/sscl_checker.sv
/*
  port checker for sscl_top: power gating, load timing, relock pulse.
  assumes: bound to sscl_top; chip enable and strobe pass a 2-stage sync.
*/
`timescale 1ns/10ps
`include "sscl_defines.svh"
module sscl_checker (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic chip_en_i,
  input wire logic load_strobe_i,
  input wire logic [`SSCL_PWR_W-1:0] pwr_on_o,
  input wire logic relock_start_o,
  input wire logic fast_settle_output_o,
  input wire logic fast_settle_output_oe_o,
  input wire logic [`SSCL_DATA_W-1:0] cfg0_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  chk_pwr_gated_off: assert property (!chip_en_i [*4] |-> pwr_on_o == '0)
    else $error("power on while chip disabled");
  chk_pwr_needs_en: assert property (pwr_on_o != '0 |->
    $past(chip_en_i, 2) || $past(chip_en_i, 3) || $past(chip_en_i, 4))
    else $error("power on without chip enable");
  // window of 8 spans the sync delay after reset release
  chk_pwr_steady: assert property ((chip_en_i && !load_strobe_i) [*8] |->
    $stable(pwr_on_o))
    else $error("power changed with no cause");
  chk_cfg0_cause: assert property (!$stable(cfg0_o) |->
    load_strobe_i || $past(load_strobe_i))
    else $error("first word changed without strobe");
  chk_relock_cause: assert property (relock_start_o |->
    $past(load_strobe_i, 2) || $past(load_strobe_i, 3))
    else $error("relock without load");
  chk_relock_one: assert property (relock_start_o |=> !relock_start_o)
    else $error("relock pulse too long");
  chk_od_low: assert property (fast_settle_output_o == 1'b0)
    else $error("open drain driven high");
  chk_reset_clear: assert property ($fell(rst_i) |->
    pwr_on_o == '0 && !relock_start_o && cfg0_o == '0)
    else $error("outputs not clear after reset");
  // the pin is only pulled after an output-config load or a relock load
  chk_oe_rise_cause: assert property ($rose(fast_settle_output_oe_o) |->
    $past(load_strobe_i) || $past(load_strobe_i, 2))
    else $error("open drain pulled without load");
endmodule // sscl_checker

// File: dv/sscl_host.sv
/*
  host model: shifts words on a 12 ns serial clock, then pulses the strobe.
  assumes: mclk_i is the 25 MHz system clock.
*/
`timescale 1ns/10ps
`include "sscl_defines.svh"
module sscl_host
  import sscl_pkg::*;
(
  input wire logic mclk_i,
  output logic ser_clk_o,
  output logic ser_data_o,
  output logic load_strobe_o
);
  initial begin
    ser_clk_o = 1'b0;
    ser_data_o = 1'b0;
    load_strobe_o = 1'b0;
  end
  task automatic send(input sscl_word_type w);
    for (int i = `SSCL_WORD_W - 1; i >= 0; i--) begin
      #3 ser_data_o = w[i];
      #3 ser_clk_o = 1'b1;
      #6 ser_clk_o = 1'b0;
    end
    // released line must not keep the last bit
    ser_data_o = ~w[0];
    @(posedge mclk_i) load_strobe_o <= 1'b1;
    repeat (5) @(posedge mclk_i);
    load_strobe_o <= 1'b0;
    repeat (4) @(posedge mclk_i);
  endtask
endmodule // sscl_host

// File: dv/sscl_top_tb.sv
/*
  testbench for sscl_top: loads, power gating, monitor mux, fast settle.
  assumes: sscl_host drives the serial lines.
*/
`timescale 1ns/10ps
`include "sscl_defines.svh"
bind sscl_top sscl_checker chk (.mclk_i, .rst_i, .chip_en_i, .load_strobe_i, .pwr_on_o,
  .relock_start_o, .fast_settle_output_o, .fast_settle_output_oe_o, .cfg0_o);
module synth_serial_config_load_tb;
  import sscl_pkg::*;
  logic mclk_i = 1'b0, rst_i = 1'b1, chip_en_i = 1'b0, pll_locked_i = 1'b0;
  logic ser_clk, ser_data, strobe, relock_start_o, oe, lock_mon;
  logic [`SSCL_PWR_W-1:0] pwr_on_o;
  logic [`SSCL_LF_W-1:0] loop_filter_o;
  logic [`SSCL_DATA_W-1:0] cfg0_o;
  int bad_count = 0, cmp_count = 0, cyc = 0, relocks = 0;
  sscl_host host (.mclk_i, .ser_clk_o(ser_clk), .ser_data_o(ser_data), .load_strobe_o(strobe));
  sscl_top dut (.mclk_i, .rst_i, .ser_clk_i(ser_clk), .ser_data_i(ser_data),
    .load_strobe_i(strobe), .chip_en_i, .pll_locked_i, .pwr_on_o, .relock_start_o,
    .fast_settle_output_o(), .fast_settle_output_oe_o(oe), .lock_monitor_output_o(lock_mon),
    .loop_filter_o, .cfg0_o);
  task automatic results;
    if (bad_count == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [23:0] s, input logic [23:0] e);
    cmp_count++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, s, e);
    end
  endtask
  task automatic ld(input logic [3:0] s, input logic [19:0] d);
    sscl_word_type w;
    w.sel = s;
    w.data = d;
    host.send(w);
  endtask
  task automatic t_down;
    ld(4'h0, 20'hA5C3E);
    chk(24'(cfg0_o), 24'hA5C3E);
    chk(24'(pwr_on_o), 24'h0);
    ld(4'h7, 20'h12345);
    chk(24'(cfg0_o), 24'hA5C3E);
  endtask
  task automatic t_power;
    ld(4'h1, 20'h00005);
    chip_en_i <= 1'b1;
    repeat (5) @(posedge mclk_i);
    chk(24'(pwr_on_o), 24'h5);
    ld(4'h0, 20'h0BEEF);
    chk(24'(relocks), 24'h1);
  endtask
  task automatic t_mon;
    logic [2:0] m [5] = '{3'h0, 3'h2, 3'h4, 3'h5, 3'h1};
    pll_locked_i <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      ld(4'h2, {13'h0, m[i], 4'h0});
      chk(24'(lock_mon), 24'(i != 0));
    end
    pll_locked_i <= 1'b0;
    repeat (4) @(posedge mclk_i);
    chk(24'(lock_mon), 24'h0);
  endtask
  task automatic t_fast;
    logic o1;
    ld(4'h2, 20'h00002);
    o1 = oe;
    ld(4'h2, 20'h00000);
    chk(24'(o1), 24'h1);
    chk(24'(oe), 24'h0);
    ld(4'h3, 20'h03412);
    ld(4'h2, 20'h00031);
    ld(4'h0, 20'h0BEEF);
    chk(24'(loop_filter_o), 24'h34);
    chk(24'(oe), 24'h1);
    chk(24'(lock_mon), 24'h1);
    repeat (`SSCL_FS_CYCLES - 10) @(posedge mclk_i);
    chk(24'(loop_filter_o), 24'h34);
    repeat (20) @(posedge mclk_i);
    chk(24'(loop_filter_o), 24'h12);
    chk(24'(oe), 24'h0);
    chk(24'(lock_mon), 24'h0);
    chip_en_i <= 1'b0;
    repeat (5) @(posedge mclk_i);
    chk(24'(pwr_on_o), 24'h0);
  endtask
  always #20 mclk_i = ~mclk_i;
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (relock_start_o === 1'b1) relocks <= relocks + 1;
    if (cyc == 3000) begin
      bad_count++;
      results;
    end
  end
  initial begin
    repeat (12) @(posedge mclk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    t_down;
    t_power;
    t_mon;
    t_fast;
    results;
  end
endmodule // synth_serial_config_load_tb
